// >>> inc/tdm_port_params.svh
`ifndef TDM_PORT_PARAMS_SVH
`define TDM_PORT_PARAMS_SVH

// Port count and line widths
`define PORT_COUNT 8
`define SLOT_W 8
// Frame lengths in bit periods per mode
`define T1_FRAME_BITS 9'd193
`define E1_FRAME_BITS 9'd256
`define NX_FRAME_BITS 9'd256
// Nx64 transmit bit 0 follows the sync rise by this many bit periods
`define NX_TX_DELAY 9'd4
// Register offsets (word index on the plain register port)
`define REG_MODE 4'h0
`define REG_EDGE 4'h1
`define REG_FLY 4'h2
`define REG_IDLE 4'h3
`define REG_TXLOCK 4'h4
`define REG_RXLOCK 4'h5
`define REG_OOF 4'h6
// Reset values
`define MODE_RST 16'h0000
`define EDGE_RST 16'h0000
`define FLY_RST 8'h00
`define IDLE_RST 8'h00

`endif

// >>> inc/tdm_port_pkg.sv
package tdm_port_pkg;

    // Framing mode of one port
    typedef enum logic [1:0] {
        MODE_T1 = 2'h0,
        MODE_E1 = 2'h1,
        MODE_NX = 2'h2
    } line_mode_t;

    // Alignment state, Gray order along hunt -> pending -> locked
    typedef enum logic [1:0] {
        ALIGN_HUNT = 2'b00,
        ALIGN_PEND = 2'b01,
        ALIGN_LOCK = 2'b11
    } align_state_t;

endpackage : tdm_port_pkg

// >>> core/tdm_lane.sv
`timescale 1ns/1ps
`include "tdm_port_params.svh"

module tdm_lane
    import tdm_port_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic rst_n,
    // Line pins
    input wire logic txLineClockPin,
    input wire logic txFrameSyncPin,
    input wire logic rxLineClockPin,
    input wire logic rxFrameSyncPin,
    input wire logic rxSerialInPin,
    input wire logic rxOutOfFramePin,
    output logic txSerialOut,
    output logic txSerialOe,
    // Configuration
    input wire logic [1:0] lineMode,
    input wire logic txSyncEdgeSelect,
    input wire logic rxSyncEdgeSelect,
    input wire logic flywheelAlignSelect,
    input wire logic idleSlotTristateSelect,
    // Controller side
    input wire logic txBitData,
    input wire logic txSlotMapped,
    output logic [8:0] txBitSlot,
    output logic txBitStrobe,
    output logic txFrameStart,
    output logic [8:0] rxBitSlot,
    output logic rxBitData,
    output logic rxBitStrobe,
    output logic rxFrameStart,
    output logic txLocked,
    output logic rxLocked,
    output logic rxOutOfFrame
);

    // =========================================================
    // State
    typedef struct packed {
        logic [1:0] tclkSync;
        logic tclkLast;
        logic [1:0] tsyncSync;
        logic tsyncLast;
        logic [1:0] rclkSync;
        logic rclkLast;
        logic [1:0] rsyncSync;
        logic rsyncLast;
        logic [1:0] rdatSync;
        logic [1:0] roofSync;
        logic rdatHold;
        logic [8:0] txCount;
        logic [8:0] txDelay;
        align_state_t txState;
        align_state_t rxState;
        logic [8:0] rxCount;
        logic txOut;
        logic txOe;
        logic [8:0] txSlot;
        logic txStb;
        logic txFs;
        logic [8:0] rxSlot;
        logic rxBit;
        logic rxStb;
        logic rxFs;
        logic rxOof;
        logic txSyncSeen;
        logic rxSyncSeen;
    } lane_state_t;

    lane_state_t st_r;
    lane_state_t st_nxt;

    // Frame length for the selected mode
    function automatic logic [8:0] frameBits(input logic [1:0] m);
        case (m)
            MODE_T1: frameBits = `T1_FRAME_BITS;
            MODE_E1: frameBits = `E1_FRAME_BITS;
            default: frameBits = `NX_FRAME_BITS;
        endcase
    endfunction : frameBits

    logic [8:0] lastBit;
    logic tRise;
    logic tFall;
    logic rRise;
    logic rFall;
    logic txActive;
    logic rxActive;
    logic txSyncEdge;
    logic rxSyncEdge;
    logic txSyncRise;
    logic rxSyncRise;
    logic [8:0] txNextCount;
    logic txSyncNow;
    logic rxSyncNow;

    // Edge finding looks only at second stages, never the first
    always_comb
    begin
        lastBit = frameBits(lineMode) - 9'd1;
        tRise = st_r.tclkSync[1] & ~st_r.tclkLast;
        tFall = ~st_r.tclkSync[1] & st_r.tclkLast;
        rRise = st_r.rclkSync[1] & ~st_r.rclkLast;
        rFall = ~st_r.rclkSync[1] & st_r.rclkLast;
        // Data launch on rising edge; sync sampled on selected edge
        txActive = tRise;
        txSyncEdge = txSyncEdgeSelect ? tFall : tRise;
        rxActive = rFall;
        rxSyncEdge = rxSyncEdgeSelect ? rRise : rFall;
        txSyncRise = txSyncEdge & st_r.tsyncSync[1] & ~st_r.tsyncLast;
        rxSyncRise = rxSyncEdge & st_r.rsyncSync[1] & ~st_r.rsyncLast;
        txNextCount = (st_r.txCount == lastBit) ? 9'd0 : st_r.txCount + 9'd1;
        // Frame start acts only on a data edge
        txSyncNow = txActive & (txSyncRise | st_r.txSyncSeen);
        rxSyncNow = rxActive & (rxSyncRise | st_r.rxSyncSeen);
    end

    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.txStb = 1'b0;
        st_nxt.txFs = 1'b0;
        st_nxt.rxStb = 1'b0;
        st_nxt.rxFs = 1'b0;
        st_nxt.tclkSync = {st_r.tclkSync[0], txLineClockPin};
        st_nxt.tclkLast = st_r.tclkSync[1];
        st_nxt.rclkSync = {st_r.rclkSync[0], rxLineClockPin};
        st_nxt.rclkLast = st_r.rclkSync[1];
        st_nxt.tsyncSync = {st_r.tsyncSync[0], txFrameSyncPin};
        st_nxt.rsyncSync = {st_r.rsyncSync[0], rxFrameSyncPin};
        st_nxt.rdatSync = {st_r.rdatSync[0], rxSerialInPin};
        st_nxt.roofSync = {st_r.roofSync[0], rxOutOfFramePin};
        st_nxt.rxOof = st_r.roofSync[1];
        // Sync caught on the other edge marks the bit of the next data edge
        st_nxt.txSyncSeen = txActive ? 1'b0 : (st_r.txSyncSeen | txSyncRise);
        st_nxt.rxSyncSeen = rxActive ? 1'b0 : (st_r.rxSyncSeen | rxSyncRise);
        if (txSyncEdge)
        begin
            st_nxt.tsyncLast = st_r.tsyncSync[1];
        end
        if (rxSyncEdge)
        begin
            st_nxt.rsyncLast = st_r.rsyncSync[1];
        end
        if (rxActive)
        begin
            st_nxt.rdatHold = st_r.rdatSync[1];
        end
        // ===== Transmit alignment
        if (txSyncNow)
        begin
            if (lineMode == MODE_NX)
            begin
                st_nxt.txState = ALIGN_PEND;
                st_nxt.txDelay = `NX_TX_DELAY;
            end
            else
            begin
                st_nxt.txState = ALIGN_LOCK;
                st_nxt.txCount = 9'd0;
            end
        end
        else if (txActive)
        begin
            case (st_r.txState)
                ALIGN_PEND:
                begin
                    st_nxt.txDelay = st_r.txDelay - 9'd1;
                    if (st_r.txDelay == 9'd1)
                    begin
                        st_nxt.txState = ALIGN_LOCK;
                        st_nxt.txCount = 9'd0;
                    end
                end
                ALIGN_LOCK:
                begin
                    // Without flywheel, wrap waits for a fresh sync
                    if (st_r.txCount == lastBit && !flywheelAlignSelect)
                    begin
                        st_nxt.txState = ALIGN_HUNT;
                    end
                    else
                    begin
                        st_nxt.txCount = txNextCount;
                    end
                end
                default:
                    st_nxt.txState = ALIGN_HUNT;
            endcase
        end
        // Bit launch uses the count valid for this period
        if (txActive)
        begin
            if (st_nxt.txState == ALIGN_LOCK && txSlotMapped)
            begin
                st_nxt.txOut = txBitData;
                st_nxt.txOe = 1'b1;
            end
            else
            begin
                // Idle slot: float or mark high
                st_nxt.txOut = 1'b1;
                st_nxt.txOe = ~idleSlotTristateSelect;
            end
            st_nxt.txStb = (st_nxt.txState == ALIGN_LOCK);
            st_nxt.txSlot = st_nxt.txCount;
            st_nxt.txFs = (st_nxt.txState == ALIGN_LOCK) && (st_nxt.txCount == 9'd0);
        end
        // ===== Receive alignment
        if (rxActive)
        begin
            if (rxSyncNow)
            begin
                st_nxt.rxState = ALIGN_LOCK;
                st_nxt.rxCount = 9'd0;
            end
            else
            begin
                case (st_r.rxState)
                    ALIGN_LOCK:
                    begin
                        if (st_r.rxCount == lastBit && !flywheelAlignSelect)
                        begin
                            st_nxt.rxState = ALIGN_HUNT;
                        end
                        else
                        begin
                            st_nxt.rxCount = (st_r.rxCount == lastBit) ?
                                9'd0 : st_r.rxCount + 9'd1;
                        end
                    end
                    default:
                        st_nxt.rxState = ALIGN_HUNT;
                endcase
            end
            // Out-of-frame data is withheld, counting continues
            st_nxt.rxStb = (st_nxt.rxState == ALIGN_LOCK) && !st_r.roofSync[1];
            st_nxt.rxBit = st_r.rdatSync[1];
            st_nxt.rxSlot = st_nxt.rxCount;
            st_nxt.rxFs = (st_nxt.rxState == ALIGN_LOCK) && (st_nxt.rxCount == 9'd0);
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops, lock flags decoded from state
    assign txSerialOut = st_r.txOut;
    assign txSerialOe = st_r.txOe;
    assign txBitSlot = st_r.txSlot;
    assign txBitStrobe = st_r.txStb;
    assign txFrameStart = st_r.txFs;
    assign rxBitSlot = st_r.rxSlot;
    assign rxBitData = st_r.rxBit;
    assign rxBitStrobe = st_r.rxStb;
    assign rxFrameStart = st_r.rxFs;
    assign txLocked = (st_r.txState == ALIGN_LOCK);
    assign rxLocked = (st_r.rxState == ALIGN_LOCK);
    assign rxOutOfFrame = st_r.rxOof;

    // =========================================================
    // Checks
    sequence txDelayRun_s;
        st_r.txState == ALIGN_PEND;
    endsequence

    txIdle_a: assert property (@(posedge clock) disable iff (!rst_n)
        (st_r.txOe && !txLocked) |-> st_r.txOut)
        else $error("idle slot not driven high");
    txLaunchEdge_a: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(st_r.txOut) |-> $past(tRise))
        else $error("tx data changed off line clock edge");
    nxDelay_a: assert property (@(posedge clock) disable iff (!rst_n)
        (txSyncNow && lineMode == MODE_NX) |=> txDelayRun_s)
        else $error("nx64 delay not started");
    txAlign_a: assert property (@(posedge clock) disable iff (!rst_n)
        (txSyncNow && lineMode != MODE_NX) |=> (txLocked && st_r.txCount == 9'd0))
        else $error("tx frame not aligned to sync");
    rxAlign_a: assert property (@(posedge clock) disable iff (!rst_n)
        rxSyncNow |=> (rxFrameStart && rxBitSlot == 9'd0))
        else $error("rx frame start missing");
    rxOof_a: assert property (@(posedge clock) disable iff (!rst_n)
        (rxActive && st_r.roofSync[1]) |=> !rxBitStrobe)
        else $error("rx strobe during out of frame");
    rxStbEdge_a: assert property (@(posedge clock) disable iff (!rst_n)
        rxBitStrobe |-> $past(rxActive))
        else $error("rx strobe off receive edge");
    txSyncEdge_a: assert property (@(posedge clock) disable iff (!rst_n)
        txSyncRise |-> (txSyncEdgeSelect ? tFall : tRise))
        else $error("tx sync on wrong edge");

endmodule : tdm_lane

// >>> core/tdm_serial_port_frame_sync.sv
`timescale 1ns/1ps
`include "tdm_port_params.svh"

// Function
// - Transmit data changes only on the transmit line clock active edge.
// - Transmit sync sampled on the edge chosen per port.
// - Rising sampled transmit sync starts a transmit frame.
// - T1 framing bit or E1 bit 0 sent in the sync-rise period.
// - Nx64 transmit bit 0 goes out four bit periods after sync rise.
// - Flywheel tracks transmit frames; otherwise each frame needs fresh sync.
// - Unmapped transmit slots float or drive one, per idle select.
// - Receive data and sync sampled on the receive line clock edge.
// - Receive sync sampled on the edge chosen per port.
// - Rising sampled receive sync starts a receive frame.
// - Bit in the sync-rise period is framing bit or bit 0.
// - Flywheel tracks receive frames; otherwise each frame needs fresh sync.
// - Out-of-frame input withholds receive bits; processing resumes on release.
module tdm_serial_port_frame_sync
    import tdm_port_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    // Line pins, one bit per port
    input wire logic [7:0] tx_line_clock,
    input wire logic [7:0] tx_frame_sync,
    output logic [7:0] tx_serial_out,
    output logic [7:0] tx_serial_out_oe,
    input wire logic [7:0] rx_line_clock,
    input wire logic [7:0] rx_frame_sync,
    input wire logic [7:0] rx_serial_in,
    input wire logic [7:0] rx_out_of_frame_in,
    // Controller side, one bit per port except the 9-bit slot buses
    input wire logic [7:0] txBitData,
    input wire logic [7:0] txSlotMapped,
    output logic [71:0] txBitSlot,
    output logic [7:0] txBitStrobe,
    output logic [7:0] txFrameStart,
    output logic [71:0] rxBitSlot,
    output logic [7:0] rxBitData,
    output logic [7:0] rxBitStrobe,
    output logic [7:0] rxFrameStart
);

    // =========================================================
    // Registers
    typedef struct packed {
        logic [15:0] mode;
        logic [7:0] txEdge;
        logic [7:0] rxEdge;
        logic [7:0] fly;
        logic [7:0] idle;
        logic [15:0] rdData;
    } regs_t;

    regs_t rg_r;
    regs_t rg_nxt;
    logic [7:0] txLocked;
    logic [7:0] rxLocked;
    logic [7:0] rxOof;

    // Software settings steer each lane; status reads back lock state
    always_comb
    begin
        rg_nxt = rg_r;
        if (regWrite)
        begin
            case (regAddr)
                `REG_MODE: rg_nxt.mode = regWrData;
                `REG_EDGE: {rg_nxt.rxEdge, rg_nxt.txEdge} = regWrData;
                `REG_FLY: rg_nxt.fly = regWrData[7:0];
                `REG_IDLE: rg_nxt.idle = regWrData[7:0];
                default: rg_nxt.fly = rg_r.fly;
            endcase
        end
        // Unmapped addresses read zero
        rg_nxt.rdData = 16'h0000;
        if (regRead)
        begin
            case (regAddr)
                `REG_MODE: rg_nxt.rdData = rg_r.mode;
                `REG_EDGE: rg_nxt.rdData = {rg_r.rxEdge, rg_r.txEdge};
                `REG_FLY: rg_nxt.rdData = {8'h00, rg_r.fly};
                `REG_IDLE: rg_nxt.rdData = {8'h00, rg_r.idle};
                `REG_TXLOCK: rg_nxt.rdData = {8'h00, txLocked};
                `REG_RXLOCK: rg_nxt.rdData = {8'h00, rxLocked};
                `REG_OOF: rg_nxt.rdData = {8'h00, rxOof};
                default: rg_nxt.rdData = 16'h0000;
            endcase
        end
    end

    // Register state
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rg_r.mode <= `MODE_RST;
            {rg_r.rxEdge, rg_r.txEdge} <= `EDGE_RST;
            rg_r.fly <= `FLY_RST;
            rg_r.idle <= `IDLE_RST;
            rg_r.rdData <= 16'h0000;
        end
        else
        begin
            rg_r <= rg_nxt;
        end
    end

    assign regRdData = rg_r.rdData;

    // =========================================================
    // Eight independent lanes
    genvar gi;
    generate
        for (gi = 0; gi < `PORT_COUNT; gi = gi + 1)
        begin : lane
            tdm_lane u_lane (
                .clock(clock),
                .rst_n(rst_n),
                .txLineClockPin(tx_line_clock[gi]),
                .txFrameSyncPin(tx_frame_sync[gi]),
                .rxLineClockPin(rx_line_clock[gi]),
                .rxFrameSyncPin(rx_frame_sync[gi]),
                .rxSerialInPin(rx_serial_in[gi]),
                .rxOutOfFramePin(rx_out_of_frame_in[gi]),
                .txSerialOut(tx_serial_out[gi]),
                .txSerialOe(tx_serial_out_oe[gi]),
                .lineMode(rg_r.mode[2*gi +: 2]),
                .txSyncEdgeSelect(rg_r.txEdge[gi]),
                .rxSyncEdgeSelect(rg_r.rxEdge[gi]),
                .flywheelAlignSelect(rg_r.fly[gi]),
                .idleSlotTristateSelect(rg_r.idle[gi]),
                .txBitData(txBitData[gi]),
                .txSlotMapped(txSlotMapped[gi]),
                .txBitSlot(txBitSlot[9*gi +: 9]),
                .txBitStrobe(txBitStrobe[gi]),
                .txFrameStart(txFrameStart[gi]),
                .rxBitSlot(rxBitSlot[9*gi +: 9]),
                .rxBitData(rxBitData[gi]),
                .rxBitStrobe(rxBitStrobe[gi]),
                .rxFrameStart(rxFrameStart[gi]),
                .txLocked(txLocked[gi]),
                .rxLocked(rxLocked[gi]),
                .rxOutOfFrame(rxOof[gi])
            );
        end
    endgenerate

    // =========================================================
    // Checks
    rdZero_a: assert property (@(posedge clock) disable iff (!rst_n)
        !regRead |=> (regRdData == 16'h0000))
        else $error("read data outside read slot");

endmodule : tdm_serial_port_frame_sync

// >>> tb/tdm_framer_model.sv
`timescale 1ns/1ps

// ====================================================================
// Framer partner: line clock, frame sync and receive data
module tdm_framer_model (
    // Control
    input wire logic run,
    // Line side
    output logic lineClock,
    output logic frameSync,
    output logic rxSerial
);
    int bitCnt = 0;
    int kind = 0;
    int phase = 0;

    // Kind 1 spans both edges, 2 covers only a fall, 3 covers only a rise
    task automatic send_sync(input int k);
        kind = k;
    endtask : send_sync

    // 320 ns bit period; the clock parks low while run is low
    initial
    begin
        lineClock = 1'b0;
        frameSync = 1'b0;
        rxSerial = 1'b0;
        #7;
        forever
        begin
            lineClock = run;
            #80;
            // Quarter point keeps data and sync clear of both edges
            if (phase == 1 || (phase == 0 && kind == 2 && lineClock))
            begin
                bitCnt = 0;
                frameSync = (kind != 3);
                phase = (kind == 3) ? 0 : 2;
                kind = (kind == 3) ? 0 : kind;
            end
            rxSerial = bitCnt[0] ^ bitCnt[2];
            bitCnt++;
            #80;
            lineClock = 1'b0;
            #80;
            if (phase == 2)
            begin
                frameSync = 1'b0;
                phase = 0;
                kind = 0;
            end
            else if (phase == 0 && (kind == 1 || kind == 3))
            begin
                frameSync = 1'b1;
                phase = 1;
            end
            #80;
        end
    end
endmodule : tdm_framer_model

// >>> tb/tdm_serial_port_frame_sync_tb_top.sv
`timescale 1ns/1ps

// ====================================================================
// Bench for the eight-port frame sync block
module tdm_serial_port_frame_sync_tb_top;
    import tdm_port_pkg::*;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdData;
    logic [7:0] syncMask = 8'h00, oofIn = 8'h00, txData = 8'h0f, txMapped = 8'h33;
    logic [7:0] txSerialOut, txSerialOe, txStrobe, txStart, rxData, rxStrobe, rxStart;
    logic [71:0] txSlot, rxSlot;
    logic run = 1'b0;
    logic lineClock, frameSync, rxSerial;
    int cyc = 0;
    int nFail = 0;
    int cmpCount = 0;

    // 25 MHz system clock and a free cycle count for timing checks
    always #20 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    tdm_framer_model tdm_framer_model_inst (
        .run(run),
        .lineClock(lineClock),
        .frameSync(frameSync),
        .rxSerial(rxSerial)
    );

    tdm_serial_port_frame_sync tdm_serial_port_frame_sync_inst (
        .clock(clock),
        .rst_n(rst_n),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdData(regRdData),
        .tx_line_clock({8{lineClock}}),
        .tx_frame_sync({8{frameSync}} & syncMask),
        .tx_serial_out(txSerialOut),
        .tx_serial_out_oe(txSerialOe),
        .rx_line_clock({8{lineClock}}),
        .rx_frame_sync({8{frameSync}} & syncMask),
        .rx_serial_in({8{rxSerial}}),
        .rx_out_of_frame_in(oofIn),
        .txBitData(txData),
        .txSlotMapped(txMapped),
        .txBitSlot(txSlot),
        .txBitStrobe(txStrobe),
        .txFrameStart(txStart),
        .rxBitSlot(rxSlot),
        .rxBitData(rxData),
        .rxBitStrobe(rxStrobe),
        .rxFrameStart(rxStart)
    );

    // ================================================================
    // Compare, bus and wait helpers
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            nFail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp16

    task automatic cmpN(input int got, input int exp);
        cmpCount++;
        if (got != exp)
        begin
            nFail++;
            $display("[ERR] %0t count %0d want %0d", $time, got, exp);
        end
    endtask : cmpN

    // Port 1 receive bits follow the framer pattern of their slot
    always @(posedge clock)
    begin
        #1;
        if (rxStrobe[1] === 1'b1)
            cmp16({15'h0000, rxData[1]}, {15'h0000, rxSlot[9] ^ rxSlot[11]});
    end

    // Reset also parks the line so no stale frame runs on
    task automatic rst_dut();
        @(posedge clock);
        rst_n <= 1'b0;
        run <= 1'b0;
        syncMask <= 8'h00;
        oofIn <= 8'h00;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
    endtask : rst_dut

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        cmp16(regRdData, exp);
    endtask : rdchk

    task automatic start(input logic [7:0] m, input int kind);
        @(posedge clock);
        syncMask <= m;
        run <= 1'b1;
        tdm_framer_model_inst.send_sync(kind);
    endtask : start

    // First tx and rx frame starts on port 1, bounded
    task automatic wait_both(input int bound, output int ta, output int tr,
                             output logic [7:0] vec, output logic [8:0] slot);
        ta = -1;
        tr = -1;
        vec = 8'h00;
        slot = 9'h1ff;
        for (int i = 0; i < bound && (ta < 0 || tr < 0); i++)
        begin
            @(posedge clock);
            #1;
            if (ta < 0 && txStart[1] === 1'b1)
            begin
                ta = cyc;
                vec = txStart;
                slot = txSlot[17:9];
            end
            if (tr < 0 && rxStart[1] === 1'b1)
                tr = cyc;
        end
    endtask : wait_both

    task automatic count_rx(output int p0, output int p1);
        p0 = 0;
        p1 = 0;
        repeat (200)
        begin
            @(posedge clock);
            #1;
            p0 += int'(rxStrobe[0] === 1'b1);
            p1 += int'(rxStrobe[1] === 1'b1);
        end
    endtask : count_rx

    // ================================================================
    // Scenarios
    task automatic test_regs();
        logic [15:0] vals [4] = '{16'h9a65, 16'ha53c, 16'h003c, 16'h00c3};
        rst_dut();
        for (int a = 0; a < 4; a++)
        begin
            rdchk(a[3:0], 16'h0000);
            wr(a[3:0], vals[a]);
            rdchk(a[3:0], vals[a]);
        end
        wr(4'h4, 16'hffff);
        rdchk(4'h4, 16'h0000);
        rdchk(4'h9, 16'h0000);
    endtask : test_regs

    // One T1 frame on half the ports, idle slots mixed float and one
    task automatic test_t1();
        int ta, tr, n, k;
        logic [7:0] vec, mm;
        logic [8:0] slot;
        rst_dut();
        wr(4'h3, 16'h0005);
        start(8'h5a, 1);
        wait_both(80, ta, tr, vec, slot);
        cmp16({8'h00, vec}, 16'h005a);
        cmp16({7'h00, slot}, 16'h0000);
        mm = 8'h5a & txMapped;
        n = 1;
        k = 0;
        repeat (1700)
        begin
            @(posedge clock);
            #1;
            if (k == 1)
            begin
                cmp16({8'h00, txSerialOe}, {8'h00, mm | 8'hfa});
                cmp16({8'h00, txSerialOut}, {8'h00, (mm & txData) | ~mm});
            end
            k = (txStrobe[1] === 1'b1) ? 5 : k - 1;
            n += int'(txStrobe[1] === 1'b1);
        end
        cmpN(n, 193);
        rdchk(4'h4, 16'h0000);
        rdchk(4'h5, 16'h0000);
    endtask : test_t1

    // Sync pulses that cover only one clock edge
    task automatic test_edges();
        logic [7:0] tx, rx;
        for (int i = 0; i < 2; i++)
        begin
            rst_dut();
            wr(4'h1, i ? 16'h0f00 : 16'h00f0);
            start(8'hff, i ? 3 : 2);
            tx = 8'h00;
            rx = 8'h00;
            repeat (40)
            begin
                @(posedge clock);
                #1;
                tx |= txStart;
                rx |= rxStart;
            end
            cmp16({tx, rx}, i ? 16'hff0f : 16'hf0ff);
        end
    endtask : test_edges

    // E1 flywheel over two frames, out of frame on port 0
    task automatic test_fly();
        int t0, t1, t2, t3, p0, p1;
        logic [7:0] vec;
        logic [8:0] slot;
        rst_dut();
        wr(4'h0, 16'h5555);
        wr(4'h2, 16'h00ff);
        start(8'hff, 1);
        wait_both(80, t0, t2, vec, slot);
        wait_both(2100, t1, t3, vec, slot);
        cmpN(t1 - t0, 2048);
        cmpN(t3 - t2, 2048);
        cmp16({7'h00, slot}, 16'h0000);
        rdchk(4'h5, 16'h00ff);
        @(posedge clock);
        oofIn <= 8'h01;
        repeat (16) @(posedge clock);
        rdchk(4'h6, 16'h0001);
        count_rx(p0, p1);
        cmpN(p0, 0);
        cmpN(p1, 25);
        @(posedge clock);
        oofIn <= 8'h00;
        repeat (16) @(posedge clock);
        count_rx(p0, p1);
        cmpN(p0, 25);
    endtask : test_fly

    // Nx64 transmit start lags E1 by four bit periods
    task automatic test_nx();
        int d [2];
        int ta, tr;
        logic [7:0] vec;
        logic [8:0] slot;
        for (int i = 0; i < 2; i++)
        begin
            rst_dut();
            wr(4'h0, i ? 16'haaaa : 16'h5555);
            start(8'hff, 1);
            wait_both(120, ta, tr, vec, slot);
            d[i] = ta - tr;
            cmp16({8'h00, vec}, 16'h00ff);
            cmp16({7'h00, slot}, 16'h0000);
        end
        cmpN(d[1] - d[0], 32);
    endtask : test_nx

    // ================================================================
    // Verdict, main sequence and watchdog
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    initial
    begin
        test_regs();
        test_t1();
        test_edges();
        test_fly();
        test_nx();
        conclude();
    end

    // Whole run needs about 4600 cycles; this is well past it
    initial
    begin
        #1000000;
        nFail++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end
endmodule : tdm_serial_port_frame_sync_tb_top
